// File: hdl/pdc_pkg.sv
// Package for the power-down control bank: offsets, field positions,
// reset values and the packed control word.
// Assumes byte-wide registers on a 16-bit address from the serial port.
package pdc_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_OUT = 2;

  // Register offsets
  localparam logic [15:0] LOCK_DBL_OFS = 16'h006c;
  localparam logic [15:0] REF_IN_OFS = 16'h006d;
  localparam logic [15:0] RSVD_OFS = 16'h006e;
  localparam logic [15:0] OUT_OFF_OFS = 16'h006f;
  localparam logic [15:0] LOOP_OFF_OFS = 16'h0070;

  // Field positions
  localparam int DBL_OFF_BIT = 0;
  localparam int LCK_MODE_BIT = 1;
  localparam int REF_OFF_BIT = 0;
  localparam int OUT0_OFF_BIT = 0;
  localparam int CAL_HOLD_BIT = 0;
  localparam int MOD_OFF_BIT = 1;
  localparam int DLOOP_OFF_BIT = 2;

  // Reset values and read value of reserved bits
  localparam logic RST_BIT = 1'b0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Enables, alarm and synchroniser state after reset
  localparam logic EN_RST = ~RST_BIT;
  localparam logic ALARM_RST = 1'b1;
  localparam logic [1:0] SYNC_RST = 2'h0;

  // Register selector decoded from the address
  typedef enum logic [2:0] {
    PDC_SEL_NONE = 3'h0,
    PDC_SEL_LOCK_DBL = 3'h1,
    PDC_SEL_REF_IN = 3'h3,
    PDC_SEL_RSVD = 3'h2,
    PDC_SEL_OUT_OFF = 3'h6,
    PDC_SEL_LOOP_OFF = 3'h7
  } pdc_sel_t;

  // All control bits of the bank
  typedef struct packed {
    logic lock_alarm_release_mode;
    logic crystal_doubler_off;
    logic reference_input_off;
    logic [NUM_OUT-1:0] output_pair_off;
    logic digital_loop_off;
    logic modulator_off;
    logic calibration_hold;
  } pdc_ctrl_t;

  localparam pdc_ctrl_t CTRL_RESET = '0;

endpackage

// File: hdl/pdc_lock_alarm.sv
// Loss-of-lock alarm release qualifier.
// Assumes lock and stability indications arrive from analog circuits,
// asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module pdc_lock_alarm (
  input wire logic clk,
  input wire logic rst,
  input wire logic release_mode,
  input wire logic pll_locked_raw,
  input wire logic outputs_stable_raw,
  output logic loss_of_lock_alarm
);

  logic [1:0] lock_sync_reg;
  logic [1:0] stable_sync_reg;
  logic alarm_reg;
  logic alarm_next;
  logic lock_s;
  logic stable_s;

  // Two-stage synchronisers; only the second stage is read
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_sync_reg <= pdc_pkg::SYNC_RST;
      stable_sync_reg <= pdc_pkg::SYNC_RST;
    end else begin
      lock_sync_reg <= {lock_sync_reg[0], pll_locked_raw};
      stable_sync_reg <= {stable_sync_reg[0], outputs_stable_raw};
    end
  end

  assign lock_s = lock_sync_reg[1];
  assign stable_s = stable_sync_reg[1];

  // Mode 1 also waits for stable outputs before releasing
  assign alarm_next = !(lock_s && (!release_mode || stable_s)); // [RQ1]

  // Alarm held asserted from reset until lock is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_reg <= pdc_pkg::ALARM_RST;
    end else begin
      alarm_reg <= alarm_next;
    end
  end

  assign loss_of_lock_alarm = alarm_reg;

endmodule
`default_nettype wire

// File: hdl/pdc_bank.sv
// Power-down and enable control bank of the clock synthesizer.
// Assumes the serial control port delivers single-cycle byte write and
// read strobes in the clk domain; pll status inputs are asynchronous.
//
// Behaviour
// [RQ1] Lock alarm drops on lock; mode one also waits for stable outputs.
// [RQ2] Doubler-off zero feeds twice crystal frequency; one feeds it unchanged.
// [RQ3] Reference-off zero enables the differential reference input; one disables.
// [RQ4] Each output off bit disables that pair's logic and tristates its driver.
// [RQ5] Digital-loop-off zero runs the digital PLL; one shuts it down.
// [RQ6] Modulator-off one disables the delta-sigma modulator; zero enables it.
// [RQ7] Calibration hold one keeps calibration in reset; zero lets it run.
// [RQ8] Software writes zero to reserved bits and ignores their read value.
// [RQ9] A written bit acts as soon as the byte write completes.
// [RQ10] Every defined control bit resets to zero, all blocks enabled.
`timescale 1ns/1ns
`default_nettype none
module pdc_bank #(
  parameter int NUM_OUT = pdc_pkg::NUM_OUT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [pdc_pkg::ADDR_W-1:0] addr,
  input wire logic [pdc_pkg::DATA_W-1:0] wdata,
  output logic [pdc_pkg::DATA_W-1:0] rdata,
  output logic rd_valid,
  input wire logic pll_locked_raw,
  input wire logic outputs_stable_raw,
  output logic loss_of_lock_alarm,
  output logic crystal_doubler_on,
  output logic reference_input_enable,
  output logic [NUM_OUT-1:0] output_logic_enable,
  output logic [NUM_OUT-1:0] output_driver_oe,
  output logic digital_loop_enable,
  output logic modulator_enable,
  output logic calibration_reset
);

  // Address decode shared by the write and read paths
  function automatic pdc_pkg::pdc_sel_t decode(
    input logic [pdc_pkg::ADDR_W-1:0] a
  );
    case (a)
      pdc_pkg::LOCK_DBL_OFS: decode = pdc_pkg::PDC_SEL_LOCK_DBL;
      pdc_pkg::REF_IN_OFS: decode = pdc_pkg::PDC_SEL_REF_IN;
      pdc_pkg::RSVD_OFS: decode = pdc_pkg::PDC_SEL_RSVD;
      pdc_pkg::OUT_OFF_OFS: decode = pdc_pkg::PDC_SEL_OUT_OFF;
      pdc_pkg::LOOP_OFF_OFS: decode = pdc_pkg::PDC_SEL_LOOP_OFF;
      default: decode = pdc_pkg::PDC_SEL_NONE;
    endcase
  endfunction

  pdc_pkg::pdc_ctrl_t ctrl_reg;
  pdc_pkg::pdc_ctrl_t ctrl_next;
  logic [pdc_pkg::DATA_W-1:0] rdata_reg;
  logic [pdc_pkg::DATA_W-1:0] rdata_next;
  logic rd_valid_reg;
  pdc_pkg::pdc_sel_t wr_sel;
  pdc_pkg::pdc_sel_t rd_sel;
  logic wr_lock_dbl;
  logic wr_ref_in;
  logic wr_out_off;
  logic wr_loop_off;
  logic [pdc_pkg::DATA_W-1:0] rd_lock_dbl;
  logic [pdc_pkg::DATA_W-1:0] rd_ref_in;
  logic [pdc_pkg::DATA_W-1:0] rd_out_off;
  logic [pdc_pkg::DATA_W-1:0] rd_loop_off;
  logic lock_mode_next;
  logic dbl_off_next;
  logic ref_off_next;
  logic [NUM_OUT-1:0] out_off_next;
  logic dloop_off_next;
  logic mod_off_next;
  logic cal_hold_next;
  logic doubler_on_reg;
  logic doubler_on_next;
  logic ref_en_reg;
  logic ref_en_next;
  logic [NUM_OUT-1:0] out_logic_en_reg;
  logic [NUM_OUT-1:0] out_logic_en_next;
  logic [NUM_OUT-1:0] out_oe_reg;
  logic [NUM_OUT-1:0] out_oe_next;
  logic dloop_en_reg;
  logic dloop_en_next;
  logic mod_en_reg;
  logic mod_en_next;
  logic cal_reset_reg;
  logic cal_reset_next;

  // Write strobes per register; reserved bytes and bits take no storage
  assign wr_sel = decode(addr);
  assign wr_lock_dbl = wr_en && (wr_sel == pdc_pkg::PDC_SEL_LOCK_DBL);
  assign wr_ref_in = wr_en && (wr_sel == pdc_pkg::PDC_SEL_REF_IN);
  assign wr_out_off = wr_en && (wr_sel == pdc_pkg::PDC_SEL_OUT_OFF);
  assign wr_loop_off = wr_en && (wr_sel == pdc_pkg::PDC_SEL_LOOP_OFF);

  // Per-field next values; a field only moves on a write to its own byte
  assign lock_mode_next = wr_lock_dbl ?
    wdata[pdc_pkg::LCK_MODE_BIT] : ctrl_reg.lock_alarm_release_mode;
  assign dbl_off_next = wr_lock_dbl ?
    wdata[pdc_pkg::DBL_OFF_BIT] : ctrl_reg.crystal_doubler_off;
  assign ref_off_next = wr_ref_in ?
    wdata[pdc_pkg::REF_OFF_BIT] : ctrl_reg.reference_input_off;
  assign out_off_next = wr_out_off ?
    wdata[pdc_pkg::OUT0_OFF_BIT +: NUM_OUT] : ctrl_reg.output_pair_off;
  assign dloop_off_next = wr_loop_off ?
    wdata[pdc_pkg::DLOOP_OFF_BIT] : ctrl_reg.digital_loop_off;
  assign mod_off_next = wr_loop_off ?
    wdata[pdc_pkg::MOD_OFF_BIT] : ctrl_reg.modulator_off;
  assign cal_hold_next = wr_loop_off ?
    wdata[pdc_pkg::CAL_HOLD_BIT] : ctrl_reg.calibration_hold;

  // Next control word gathered from the fields
  assign ctrl_next = '{
    lock_alarm_release_mode: lock_mode_next,
    crystal_doubler_off: dbl_off_next,
    reference_input_off: ref_off_next,
    output_pair_off: out_off_next,
    digital_loop_off: dloop_off_next,
    modulator_off: mod_off_next,
    calibration_hold: cal_hold_next
  };

  // Control word; no shadow copy so a write acts on the next edge
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= pdc_pkg::CTRL_RESET; // [RQ10]
    end else begin
      ctrl_reg <= ctrl_next; // [RQ9]
    end
  end

  // Read images; reserved positions read back as zero
  always_comb begin
    rd_lock_dbl = pdc_pkg::ZERO_BYTE;
    rd_lock_dbl[pdc_pkg::LCK_MODE_BIT] = ctrl_reg.lock_alarm_release_mode;
    rd_lock_dbl[pdc_pkg::DBL_OFF_BIT] = ctrl_reg.crystal_doubler_off;
    rd_ref_in = pdc_pkg::ZERO_BYTE;
    rd_ref_in[pdc_pkg::REF_OFF_BIT] = ctrl_reg.reference_input_off;
    rd_out_off = pdc_pkg::ZERO_BYTE;
    rd_out_off[pdc_pkg::OUT0_OFF_BIT +: NUM_OUT] = ctrl_reg.output_pair_off;
    rd_loop_off = pdc_pkg::ZERO_BYTE;
    rd_loop_off[pdc_pkg::DLOOP_OFF_BIT] = ctrl_reg.digital_loop_off;
    rd_loop_off[pdc_pkg::MOD_OFF_BIT] = ctrl_reg.modulator_off;
    rd_loop_off[pdc_pkg::CAL_HOLD_BIT] = ctrl_reg.calibration_hold;
  end

  // Read mux; unmapped and reserved addresses answer zero
  assign rd_sel = decode(addr);
  always_comb begin
    case (rd_sel)
      pdc_pkg::PDC_SEL_LOCK_DBL: rdata_next = rd_lock_dbl;
      pdc_pkg::PDC_SEL_REF_IN: rdata_next = rd_ref_in;
      pdc_pkg::PDC_SEL_OUT_OFF: rdata_next = rd_out_off;
      pdc_pkg::PDC_SEL_LOOP_OFF: rdata_next = rd_loop_off;
      default: rdata_next = pdc_pkg::ZERO_BYTE; // [RQ8]
    endcase
  end

  // Read data held until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= pdc_pkg::ZERO_BYTE;
      rd_valid_reg <= pdc_pkg::RST_BIT;
    end else begin
      rd_valid_reg <= rd_en;
      if (rd_en) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign rdata = rdata_reg;
  assign rd_valid = rd_valid_reg;

  // Enables worked out from the next word so the flops track the bits
  assign doubler_on_next = !ctrl_next.crystal_doubler_off; // [RQ2]
  assign ref_en_next = !ctrl_next.reference_input_off; // [RQ3]
  assign dloop_en_next = !ctrl_next.digital_loop_off; // [RQ5]
  assign mod_en_next = !ctrl_next.modulator_off; // [RQ6]
  assign cal_reset_next = ctrl_next.calibration_hold; // [RQ7]

  // Per-output gating; logic and driver go off together
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      assign out_logic_en_next[gi] = !ctrl_next.output_pair_off[gi]; // [RQ4]
      assign out_oe_next[gi] = !ctrl_next.output_pair_off[gi]; // [RQ4]
    end
  endgenerate

  // Output flops: each enable leaves the block glitch free, at the cost of
  // one flop per line; it still changes on the edge that stores its bit
  always_ff @(posedge clk) begin
    if (rst) begin
      doubler_on_reg <= pdc_pkg::EN_RST; // [RQ10]
      ref_en_reg <= pdc_pkg::EN_RST;
      out_logic_en_reg <= {NUM_OUT{pdc_pkg::EN_RST}};
      out_oe_reg <= {NUM_OUT{pdc_pkg::EN_RST}};
      dloop_en_reg <= pdc_pkg::EN_RST;
      mod_en_reg <= pdc_pkg::EN_RST;
      cal_reset_reg <= pdc_pkg::RST_BIT;
    end else begin
      doubler_on_reg <= doubler_on_next; // [RQ9]
      ref_en_reg <= ref_en_next;
      out_logic_en_reg <= out_logic_en_next;
      out_oe_reg <= out_oe_next;
      dloop_en_reg <= dloop_en_next;
      mod_en_reg <= mod_en_next;
      cal_reset_reg <= cal_reset_next;
    end
  end

  // Block enables straight from the output flops
  assign crystal_doubler_on = doubler_on_reg;
  assign reference_input_enable = ref_en_reg;
  assign output_logic_enable = out_logic_en_reg;
  assign output_driver_oe = out_oe_reg;
  assign digital_loop_enable = dloop_en_reg;
  assign modulator_enable = mod_en_reg;
  assign calibration_reset = cal_reset_reg;

  // Alarm release, qualified by the mode bit
  pdc_lock_alarm u_lock_alarm (
    .clk(clk),
    .rst(rst),
    .release_mode(ctrl_reg.lock_alarm_release_mode),
    .pll_locked_raw(pll_locked_raw),
    .outputs_stable_raw(outputs_stable_raw),
    .loss_of_lock_alarm(loss_of_lock_alarm) // [RQ1]
  );

endmodule
`default_nettype wire

// File: tb/pdc_bank_chk.sv
// Port checker for the power-down control bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module pdc_bank_chk #(
  parameter int NUM_OUT = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rd_valid,
  input wire logic pll_locked_raw,
  input wire logic outputs_stable_raw,
  input wire logic loss_of_lock_alarm,
  input wire logic crystal_doubler_on,
  input wire logic reference_input_enable,
  input wire logic [NUM_OUT-1:0] output_logic_enable,
  input wire logic [NUM_OUT-1:0] output_driver_oe,
  input wire logic digital_loop_enable,
  input wire logic modulator_enable,
  input wire logic calibration_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Byte write decode per register
  wire w_lk = wr_en && addr == pdc_pkg::LOCK_DBL_OFS;
  wire w_rf = wr_en && addr == pdc_pkg::REF_IN_OFS;
  wire w_ou = wr_en && addr == pdc_pkg::OUT_OFF_OFS;
  wire w_lp = wr_en && addr == pdc_pkg::LOOP_OFF_OFS;
  a_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read not answered");
  a_doubler_write: assert property (w_lk |=> crystal_doubler_on ==
    !$past(wdata[0])) else $error("doubler wrong");
  a_ref_write: assert property (w_rf |=> reference_input_enable ==
    !$past(wdata[0])) else $error("reference enable wrong");
  a_out_write: assert property (w_ou |=>
    output_driver_oe == ~$past(wdata[NUM_OUT-1:0]) &&
    output_logic_enable == ~$past(wdata[NUM_OUT-1:0]))
    else $error("output enables wrong");
  a_dloop_write: assert property (w_lp |=> digital_loop_enable ==
    !$past(wdata[2])) else $error("digital loop wrong");
  a_mod_write: assert property (w_lp |=> modulator_enable ==
    !$past(wdata[1])) else $error("modulator wrong");
  a_cal_write: assert property (w_lp |=> calibration_reset ==
    $past(wdata[0])) else $error("calibration wrong");
  a_reset_clear: assert property ($fell(rst) |->
    crystal_doubler_on && reference_input_enable && &output_driver_oe &&
    &output_logic_enable && digital_loop_enable && modulator_enable &&
    !calibration_reset && loss_of_lock_alarm) else $error("reset state wrong");
  a_alarm_raise: assert property (!pll_locked_raw [*3] |=>
    loss_of_lock_alarm) else $error("alarm not raised");
  a_alarm_clear: assert property ((pll_locked_raw &&
    outputs_stable_raw) [*3] |=> !loss_of_lock_alarm)
    else $error("alarm not cleared");
endmodule
bind pdc_bank pdc_bank_chk #(.NUM_OUT(NUM_OUT)) u_chk (
  .clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
  .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid),
  .pll_locked_raw(pll_locked_raw), .outputs_stable_raw(outputs_stable_raw),
  .loss_of_lock_alarm(loss_of_lock_alarm),
  .crystal_doubler_on(crystal_doubler_on),
  .reference_input_enable(reference_input_enable),
  .output_logic_enable(output_logic_enable),
  .output_driver_oe(output_driver_oe),
  .digital_loop_enable(digital_loop_enable),
  .modulator_enable(modulator_enable),
  .calibration_reset(calibration_reset)
);
`default_nettype wire

// File: tb/test_power_down_control_bank.sv
// Self-checking bench for the power-down control bank.
// Assumes pdc_bank with two output pairs; bench drives every port.
`timescale 1ns/1ns
`default_nettype none
module test_power_down_control_bank;
  logic clk = 0, rst = 1, wr_en = 0, rd_en = 0;
  logic pll_locked_raw = 0, outputs_stable_raw = 0;
  logic [15:0] addr = 16'h0000, a;
  logic [7:0] wdata = 8'h00, d;
  wire logic [7:0] rdata;
  wire logic rd_valid, loss_of_lock_alarm, crystal_doubler_on;
  wire logic reference_input_enable, digital_loop_enable, modulator_enable;
  wire logic calibration_reset;
  wire logic [1:0] output_logic_enable, output_driver_oe;
  int mismatches = 0, n_checks = 0, i;
  int mem [5] = '{default: 0};
  int msk [5] = '{3, 1, 0, 3, 7};
  pdc_bank dut (
    .clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rd_valid(rd_valid),
    .pll_locked_raw(pll_locked_raw), .outputs_stable_raw(outputs_stable_raw),
    .loss_of_lock_alarm(loss_of_lock_alarm),
    .crystal_doubler_on(crystal_doubler_on),
    .reference_input_enable(reference_input_enable),
    .output_logic_enable(output_logic_enable),
    .output_driver_oe(output_driver_oe),
    .digital_loop_enable(digital_loop_enable),
    .modulator_enable(modulator_enable),
    .calibration_reset(calibration_reset)
  );
  // Control outputs as one word for comparison
  wire logic [15:0] ctl_seen = {7'h00, crystal_doubler_on,
    reference_input_enable, output_logic_enable, output_driver_oe,
    digital_loop_enable, modulator_enable, calibration_reset};
  always #2 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Expected control word from the shadow registers
  function automatic logic [15:0] ctl();
    return {7'h00, ~mem[0][0], ~mem[1][0], ~mem[3][1:0], ~mem[3][1:0],
      ~mem[4][2], ~mem[4][1], mem[4][0]};
  endfunction
  // One access; a read sees the old value even beside a write
  task automatic op(input logic w, input logic r, input logic [15:0] ad,
    input logic [7:0] dt);
    int k;
    k = ad - 16'h006c;
    @(posedge clk) #1;
    wr_en = w;
    rd_en = r;
    addr = ad;
    wdata = dt;
    @(posedge clk) #1;
    wr_en = 0;
    rd_en = 0;
    chk({15'h0000, rd_valid}, {15'h0000, r});
    if (r) begin
      chk({8'h00, rdata}, (k >= 0 && k < 5) ? 16'(mem[k]) : 16'h0000);
    end
    if (w && k >= 0 && k < 5) mem[k] = dt & msk[k];
    chk(ctl_seen, ctl());
  endtask
  // Main sequence
  initial begin
    void'($urandom(50693));
    repeat (3) @(posedge clk);
    #1 rst = 0;
    chk({15'h0000, loss_of_lock_alarm}, 16'h0001);
    for (int x = 'h6c; x <= 'h70; x++) op(0, 1, 16'(x), 8'h00);
    // Random traffic; reserved bits kept zero on mapped bytes
    repeat (80) begin
      a = 16'h006a + 16'($urandom_range(8));
      i = a - 16'h006c;
      d = 8'($urandom) & ((i >= 0 && i < 5) ? 8'(msk[i]) : 8'hff);
      op(1'($urandom), 1'($urandom), a, d);
    end
    // Reset in mid-run clears every control bit
    @(posedge clk) #1;
    rst = 1;
    @(posedge clk) #1;
    rst = 0;
    mem = '{default: 0};
    chk(ctl_seen, ctl());
    chk({15'h0000, loss_of_lock_alarm}, 16'h0001);
    // Every mode and lock and stability combination
    for (int k = 0; k < 8; k++) begin
      op(1, 0, 16'h006c, {6'h00, k[2], 1'b0});
      pll_locked_raw = k[1];
      outputs_stable_raw = k[0];
      repeat (5) @(posedge clk);
      #1 chk({15'h0000, loss_of_lock_alarm},
        {15'h0000, !(k[1] && (!k[2] || k[0]))});
    end
    stop_test();
  end
  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #40000;
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
